/* File: jesd_8b10b_link_transmitter_tb.sv */
// Bench joining both link ends and checking recovered samples.
`timescale 1ns/100ps
`default_nettype none
module jesd_8b10b_link_transmitter_tb;
  import jtx_pkg::*;
  localparam int K = 9;
  // Lane count shared by every instance below; sample width for the sender, deskew depth for the receiver.
  localparam int NL = 2;
  localparam int SW = 12;
  localparam int DEPTH = 8;
  logic i_core_clk;
  logic i_arst_n;
  logic [1:0] mode;
  logic scramble_enable;
  logic s64;
  logic sysref;
  logic en;
  logic [23:0] sample;
  logic [15:0] octets;
  logic valid;
  logic align_err;
  logic ready;
  jtx_tx_state_t tx_st;
  jtx_rx_state_t rx_st;
  int mismatches;
  int n_checks;
  jtx_link_if #(.LANES(NL)) link ();
  jtx_tx #(.LANES(NL), .SAMPLE_W(SW), .FRAMES_PER_MF(K)) i_jtx_tx (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_transport_mode_select(mode), .i_scramble_enable(scramble_enable),
    .i_sel_64b66b(s64), .i_sysref(sysref), .i_sample(sample), .o_sample_ready(ready),
    .o_link_state(tx_st), .link(link.tx));
  jtx_rx #(.LANES(NL), .FRAMES_PER_MF(K), .SKEW_DEPTH(DEPTH)) i_jtx_rx (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_transport_mode_select(mode), .i_scramble_enable(scramble_enable),
    .i_sel_64b66b(s64), .i_sysref(sysref), .i_link_enable(en), .o_octets(octets),
    .o_valid(valid), .o_align_err(align_err), .o_link_state(rx_st), .link(link.rx));
  jtx_link_sva #(.LANES(NL), .FRAMES_PER_MF(K)) i_jtx_link_sva (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .chars(link.chars), .sync_n(link.sync_n));
  // Free-running clock at 25 MHz.
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Generous limit: the full run needs well under ten thousand cycles.
  initial begin
    #2000000;
    mismatches++;
    end_of_test();
  end
  // Each pass restarts the link in one mode, scramble and coding choice.
  initial begin
    {mode, scramble_enable, s64, sysref, en, sample} = '0;
    mismatches = 0;
    n_checks = 0;
    i_arst_n = 1'b0;
    tick(5);
    i_arst_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      {s64, scramble_enable, mode} = 4'(i);
      en = 1'b0;
      sample = {12'h35e + 12'(i), 12'habc ^ 12'(i)};
      tick(4);
      sysref = 1'b1;
      tick(2);
      sysref = 1'b0;
      en = 1'b1;
      for (int w = 0; w < 3000 && valid !== 1'b1; w++) tick(1);
      chk({14'h0, tx_st}, {14'h0, JTX_TX_DATA});
      chk({14'h0, rx_st}, {14'h0, JTX_RX_DATA});
      for (int k = 0; k < 4; k++) begin
        chk(octets, k[0] ? {sample[15:12], 4'h0, sample[3:0], 4'h0} :
          {sample[23:16], sample[11:4]});
        chk({15'h0, align_err}, 16'h0);
        // The sender runs five octets ahead of the recovered output, so its take is odd here.
        chk({15'h0, ready}, {15'h0, k[0]});
        tick(1);
      end
      $display("test %0d done", i);
    end
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: jtx_defs.svh */
// Shared constants for both ends of the 8b/10b serial link.
`ifndef JTX_DEFS_SVH
`define JTX_DEFS_SVH
`define JTX_K_R 8'h1c
`define JTX_K_A 8'h7c
`define JTX_K_Q 8'h9c
`define JTX_K_K 8'hbc
`define JTX_K_F 8'hfc
`define JTX_K_X 5'h1c
`define JTX_CHAR_W 10
`define JTX_CONT_W 16
`define JTX_MODE_F4 2'h1
`define JTX_MODE_F8 2'h2
`define JTX_F_DEF 4'h2
`define JTX_F_4 4'h4
`define JTX_F_8 4'h8
`define JTX_ILAS_LAST_MF 2'h3
`define JTX_ILAS_DONE 3'h4
`define JTX_CGS_RUN 3'h4
`define JTX_ERR_LIMIT 2'h3
`define JTX_CFG_Q 11'h1
`define JTX_CFG_LANE 11'h2
`define JTX_CFG_L 11'h3
`define JTX_CFG_F 11'h4
`define JTX_CFG_K 11'h5
`define JTX_CFG_MODE 11'h6
`endif

/* File: jtx_link_if.sv */
// Link carrier: coded lane characters one way, SYNC the other.
`timescale 1ns/100ps
`default_nettype none
interface jtx_link_if #(parameter int LANES = 2);
  // Lane l occupies bits l*10 +: 10; line bit a is the msb.
  logic [LANES*10-1:0] chars;
  // Link start request, active low, driven by the receiving end.
  logic sync_n;
  modport tx (output chars, input sync_n);
  modport rx (input chars, output sync_n);
endinterface
`default_nettype wire

/* File: jtx_link_sva.sv */
// Concurrent checks on the coded lanes and the start request.
`timescale 1ns/100ps
`default_nettype none
module jtx_link_sva #(
  parameter int LANES = 2,
  parameter int FRAMES_PER_MF = 9
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [LANES*10-1:0] chars,
  input wire logic sync_n
);
  // ==========
  // Character classes; the span allows F from two to eight.
  localparam int MF_MIN = 2 * FRAMES_PER_MF - 1;
  localparam int MF_MAX = 8 * FRAMES_PER_MF - 1;
  localparam int ILAS_MAX = MF_MAX + 10;
  localparam int QUIET = MF_MAX + 20;
  wire logic [9:0] ln0 = chars[9:0];
  wire logic [9:0] ln1 = chars[19:10];
  wire logic comma0 = (ln0 == 10'h0fa) || (ln0 == 10'h305);
  wire logic comma1 = (ln1 == 10'h0fa) || (ln1 == 10'h305);
  wire logic r0 = (ln0 == 10'h0f4) || (ln0 == 10'h30b);
  wire logic r1 = (ln1 == 10'h0f4) || (ln1 == 10'h30b);
  wire logic a0 = (ln0 == 10'h0f3) || (ln0 == 10'h30c);
  wire logic [3:0] ones0 = 4'($countones(ln0));
  wire logic [3:0] ones1 = 4'($countones(ln1));
  logic up_reg;
  logic rd0_reg;
  logic rd1_reg;
  logic seen_low_reg;
  logic [7:0] hi_cnt_reg;
  // Running disparity of lanes 0 and 1, and time since the request was released.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {up_reg, rd0_reg, rd1_reg, seen_low_reg, hi_cnt_reg} <= '0;
    end else begin
      up_reg <= 1'b1;
      rd0_reg <= (up_reg && ones0 != 4'h5) ? (ones0 == 4'h6) : rd0_reg;
      rd1_reg <= (up_reg && ones1 != 4'h5) ? (ones1 == 4'h6) : rd1_reg;
      seen_low_reg <= seen_low_reg || !sync_n;
      hi_cnt_reg <= !sync_n ? 8'h00 : hi_cnt_reg + 8'(seen_low_reg && hi_cnt_reg != 8'hff);
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  chk_lane0_disparity: assert property (
    up_reg |-> ones0 == 4'h5 || (ones0 == 4'h6 && !rd0_reg) || (ones0 == 4'h4 && rd0_reg))
    else $error("Lane 0 disparity broken.");
  chk_lane1_disparity: assert property (
    up_reg |-> ones1 == 4'h5 || (ones1 == 4'h6 && !rd1_reg) || (ones1 == 4'h4 && rd1_reg))
    else $error("Lane 1 disparity broken.");
  chk_comma_on_request: assert property (
    $fell(sync_n) |-> ##[3:6] (comma0 && comma1)) else $error("No commas after request.");
  chk_release_after_comma: assert property (
    $rose(sync_n) |-> $past(comma0, 2) && $past(comma1, 2)) else $error("Early release.");
  chk_ilas_start: assert property (
    $rose(sync_n) |-> ##[1:ILAS_MAX] r0) else $error("Alignment sequence missing.");
  chk_lanes_lockstep: assert property (
    r0 |-> r1) else $error("Lanes start multiframes apart.");
  chk_mf_span: assert property (
    r0 |-> ##[MF_MIN:MF_MAX] a0) else $error("Multiframe does not end in an A.");
  chk_no_comma_data: assert property (
    int'(hi_cnt_reg) == QUIET |-> !comma0 && !comma1) else $error("Commas during data.");
  cover property (r0 ##[MF_MIN:MF_MAX] a0);
  cover property ($rose(sync_n));
  cover property (int'(hi_cnt_reg) == QUIET);
endmodule
`default_nettype wire

/* File: jtx_pkg.sv */
// Types and shared coding functions for the serial link ends.
`default_nettype none
`include "jtx_defs.svh"
package jtx_pkg;
  // One octet before coding and one character after it.
  typedef logic [7:0] jtx_octet_t;
  typedef logic [9:0] jtx_char_t;
  // Start-up phases of the transmitting end.
  typedef enum logic [1:0] {JTX_TX_CGS, JTX_TX_WAIT, JTX_TX_ILAS, JTX_TX_DATA} jtx_tx_state_t;
  // Start-up phases of the receiving end.
  typedef enum logic [1:0] {JTX_RX_IDLE, JTX_RX_CGS, JTX_RX_ALIGN, JTX_RX_DATA} jtx_rx_state_t;

  // Octets per frame for each transport mode; unused codes fall back to two.
  function automatic logic [3:0] jtx_frame_octets(input logic [1:0] mode);
    case (mode)
      `JTX_MODE_F4: return `JTX_F_4;
      `JTX_MODE_F8: return `JTX_F_8;
      default: return `JTX_F_DEF;
    endcase
  endfunction

  // Scrambler 1 + x^14 + x^15, msb first; returns {state, octet}.
  function automatic logic [22:0] jtx_scramble(input logic [14:0] st, input jtx_octet_t d);
    logic [14:0] s;
    jtx_octet_t o;
    s = st;
    o = '0;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ s[14] ^ s[13];
      s = {s[13:0], o[i]};
    end
    return {s, o};
  endfunction

  // 8b/10b coder. Character bit 9 is line bit a. Returns {new disparity, char}.
  function automatic logic [10:0] jtx_encode(input jtx_octet_t d, input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic rd6;
    logic alt;
    case (d[4:0])
      5'h00: c6 = 6'b100111; 5'h01: c6 = 6'b011101; 5'h02: c6 = 6'b101101;
      5'h03: c6 = 6'b110001; 5'h04: c6 = 6'b110101; 5'h05: c6 = 6'b101001;
      5'h06: c6 = 6'b011001; 5'h07: c6 = 6'b111000; 5'h08: c6 = 6'b111001;
      5'h09: c6 = 6'b100101; 5'h0a: c6 = 6'b010101; 5'h0b: c6 = 6'b110100;
      5'h0c: c6 = 6'b001101; 5'h0d: c6 = 6'b101100; 5'h0e: c6 = 6'b011100;
      5'h0f: c6 = 6'b010111; 5'h10: c6 = 6'b011011; 5'h11: c6 = 6'b100011;
      5'h12: c6 = 6'b010011; 5'h13: c6 = 6'b110010; 5'h14: c6 = 6'b001011;
      5'h15: c6 = 6'b101010; 5'h16: c6 = 6'b011010; 5'h17: c6 = 6'b111010;
      5'h18: c6 = 6'b110011; 5'h19: c6 = 6'b100110; 5'h1a: c6 = 6'b010110;
      5'h1b: c6 = 6'b110110; 5'h1c: c6 = 6'b001110; 5'h1d: c6 = 6'b101110;
      5'h1e: c6 = 6'b011110; default: c6 = 6'b101011;
    endcase
    if (k) begin
      c6 = 6'b001111;
    end
    // Unbalanced codes, and the one biased balanced code, flip under positive disparity.
    if (rd && (($countones(c6) != 3) || (c6 == 6'b111000))) begin
      c6 = ~c6;
    end
    rd6 = ($countones(c6) != 3) ? ~rd : rd;
    case (d[7:5])
      3'h0: c4 = 4'b1011; 3'h1: c4 = 4'b1001; 3'h2: c4 = 4'b0101; 3'h3: c4 = 4'b1100;
      3'h4: c4 = 4'b1101; 3'h5: c4 = 4'b1010; 3'h6: c4 = 4'b0110; default: c4 = 4'b1110;
    endcase
    // The alternate x.7 form avoids a run of five equal bits.
    alt = (d[7:5] == 3'h7) && (k || (!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
          d[4:0] == 5'h14)) || (rd6 && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)));
    if (alt) begin
      c4 = 4'b0111;
    end
    if (rd6 && (($countones(c4) != 2) || (c4 == 4'b1100))) begin
      c4 = ~c4;
    end else if (k && rd && ($countones(c4) == 2) && (c4 != 4'b1100)) begin
      c4 = ~c4;
    end
    return {(($countones(c4) != 2) ? ~rd6 : rd6), c6, c4};
  endfunction
endpackage
`default_nettype wire

/* File: jtx_rx.sv */
// Receiving end: comma search, SYNC handshake, lane deskew and alignment monitor.
`timescale 1ns/100ps
`default_nettype none
`include "jtx_defs.svh"
module jtx_rx #(
  parameter int LANES = 2,
  parameter int FRAMES_PER_MF = 32,
  parameter int SKEW_DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_transport_mode_select,
  input wire logic i_scramble_enable,
  input wire logic i_sel_64b66b,
  input wire logic i_sysref,
  input wire logic i_link_enable,
  output logic [LANES*8-1:0] o_octets,
  output logic o_valid,
  output logic o_align_err,
  output var jtx_pkg::jtx_rx_state_t o_link_state,
  jtx_link_if.rx link
);
  import jtx_pkg::*;

  localparam int AW = $clog2(SKEW_DEPTH);

  // ==========================================================
  // Input synchronisers and multiframe clock
  // ==========================================================
  logic [LANES*`JTX_CHAR_W-1:0] ch_meta_reg, ch_reg;
  logic sref_meta_reg, sref_reg, sref_d_reg, sync_n_reg;
  logic [10:0] oct_reg;
  wire [3:0] frame_len = jtx_frame_octets(i_transport_mode_select);
  wire [10:0] mf_last = 11'(frame_len * FRAMES_PER_MF - 1);
  wire [10:0] frame_mask = 11'(frame_len - 4'h1);
  wire lmfc_edge = (oct_reg == mf_last);
  wire scr_on = i_scramble_enable | i_sel_64b66b;

  // Lane characters and SYSREF cross in through two flops; counter reset by SYSREF.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ch_meta_reg <= '0;
      ch_reg <= '0;
      sref_meta_reg <= 1'b0;
      sref_reg <= 1'b0;
      sref_d_reg <= 1'b0;
      oct_reg <= '0;
    end else begin
      ch_meta_reg <= link.chars;
      ch_reg <= ch_meta_reg;
      sref_meta_reg <= i_sysref;
      sref_reg <= sref_meta_reg;
      sref_d_reg <= sref_reg;
      oct_reg <= ((sref_reg & ~sref_d_reg) || lmfc_edge) ? '0 : oct_reg + 11'h1;
    end
  end

  // Reverse lookup through the coder; returns {valid, k, octet}.
  function automatic logic [9:0] decode(input logic [`JTX_CHAR_W-1:0] c);
    logic [10:0] e;
    logic [9:0] r;
    r = '0;
    for (int i = 0; i < 256; i++) begin
      for (int d = 0; d < 2; d++) begin
        e = jtx_encode(8'(i), 1'b0, d[0]);
        if (e[`JTX_CHAR_W-1:0] == c) begin
          r = {2'b10, 8'(i)};
        end
      end
    end
    for (int y = 0; y < 8; y++) begin
      for (int d = 0; d < 2; d++) begin
        e = jtx_encode({3'(y), `JTX_K_X}, 1'b1, d[0]);
        if (e[`JTX_CHAR_W-1:0] == c) begin
          r = {2'b11, 3'(y), `JTX_K_X};
        end
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Handshake sequencer
  // ==========================================================
  jtx_rx_state_t state_reg, state_next;
  logic [LANES-1:0] cgs_ok, started, start_now, misplaced;
  logic [1:0] err_reg;
  logic [2:0] ilas_mf_reg;
  logic [10:0] pos_reg;
  logic [AW-1:0] rp_reg;
  wire linked = (state_reg == JTX_RX_ALIGN) || (state_reg == JTX_RX_DATA);
  wire all_started = &started;
  wire data_ph = (ilas_mf_reg == `JTX_ILAS_DONE);
  wire r_frame_end = ((pos_reg & frame_mask) == frame_mask);
  wire r_mf_end = (pos_reg == mf_last);

  // Pull SYNC low when ready; release after all lanes see commas, on a boundary.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      JTX_RX_IDLE: if (i_link_enable) state_next = JTX_RX_CGS;
      JTX_RX_CGS: if ((&cgs_ok) && lmfc_edge) state_next = JTX_RX_ALIGN;
      JTX_RX_ALIGN: if (data_ph) state_next = JTX_RX_DATA;
      JTX_RX_DATA: state_next = JTX_RX_DATA;
      default: state_next = JTX_RX_IDLE;
    endcase
    // Repeated misalignment restarts the link through SYNC.
    if (linked && (err_reg == `JTX_ERR_LIMIT)) begin
      state_next = JTX_RX_CGS;
    end
    if (!i_link_enable) begin
      state_next = JTX_RX_IDLE;
    end
  end

  // Shared read side: all lanes are read together once each has seen /R/.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= JTX_RX_IDLE;
      sync_n_reg <= 1'b1;
      rp_reg <= '0;
      pos_reg <= '0;
      ilas_mf_reg <= '0;
      err_reg <= '0;
      o_align_err <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      state_reg <= state_next;
      sync_n_reg <= (state_next != JTX_RX_CGS);
      o_align_err <= |misplaced;
      o_valid <= linked && all_started && data_ph;
      if (!linked) begin
        rp_reg <= '0;
        pos_reg <= '0;
        ilas_mf_reg <= '0;
        err_reg <= '0;
      end else if (all_started) begin
        rp_reg <= rp_reg + 1'b1;
        pos_reg <= r_mf_end ? '0 : pos_reg + 11'h1;
        if (r_mf_end && !data_ph) begin
          ilas_mf_reg <= ilas_mf_reg + 3'h1;
        end
        if ((|misplaced) && (err_reg != `JTX_ERR_LIMIT)) begin
          err_reg <= err_reg + 2'h1;
        end
      end
    end
  end

  assign link.sync_n = sync_n_reg;
  assign o_link_state = state_reg;

  // ==========================================================
  // Lanes
  // ==========================================================
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    wire [9:0] dec = decode(ch_reg[l*`JTX_CHAR_W +: `JTX_CHAR_W]);
    logic [2:0] cgs_reg;
    logic [AW-1:0] wp_reg;
    logic [8:0] skew_mem [SKEW_DEPTH];
    logic [7:0] prev_reg;
    logic [14:0] dsc_reg;
    logic [7:0] o;
    wire comma = dec[9] & dec[8] & (dec[7:0] == `JTX_K_K);
    wire [8:0] rd = skew_mem[rp_reg];
    wire is_f = rd[8] & (rd[7:0] == `JTX_K_F);
    wire is_a = rd[8] & (rd[7:0] == `JTX_K_A);
    // /F/ and /A/ already carry 0xFC and 0x7C; plain mode repeats the last octet.
    wire [7:0] fixed = ((is_f | is_a) && !scr_on) ? prev_reg : rd[7:0];
    assign cgs_ok[l] = (cgs_reg == `JTX_CGS_RUN);
    assign start_now[l] = (state_reg == JTX_RX_ALIGN) & dec[8] & (dec[7:0] == `JTX_K_R);
    assign misplaced[l] = all_started & data_ph & ((is_f & !r_frame_end) | (is_a & !r_mf_end));

    // Self-synchronising descrambler, cleared outside data like the sender's.
    always_comb begin
      logic [14:0] s;
      s = dsc_reg;
      o = '0;
      for (int i = 7; i >= 0; i--) begin
        o[i] = fixed[i] ^ s[14] ^ s[13];
        s = {s[13:0], fixed[i]};
      end
    end

    // Write from /R/ onward; the ring absorbs the skew between lanes.
    always_ff @(posedge i_core_clk) begin
      if (started[l] || start_now[l]) begin
        skew_mem[wp_reg] <= dec[8:0];
      end
    end

    // Comma run, write pointer, frame history and output octet.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        cgs_reg <= '0;
        wp_reg <= '0;
        started[l] <= 1'b0;
        prev_reg <= '0;
        dsc_reg <= '0;
        o_octets[l*8 +: 8] <= '0;
      end else begin
        cgs_reg <= comma ? (cgs_ok[l] ? cgs_reg : cgs_reg + 3'h1) : '0;
        if (!linked) begin
          started[l] <= 1'b0;
          wp_reg <= '0;
        end else if (started[l] || start_now[l]) begin
          started[l] <= 1'b1;
          wp_reg <= wp_reg + 1'b1;
        end
        dsc_reg <= (all_started && data_ph) ? {dsc_reg[6:0], fixed} : '0;
        // Cleared outside data to match the sender's history at each new link.
        if (!data_ph) begin
          prev_reg <= '0;
        end else if (all_started && r_frame_end) begin
          prev_reg <= fixed;
        end
        o_octets[l*8 +: 8] <= scr_on ? o : fixed;
      end
    end
  end
endmodule
`default_nettype wire

/* File: jtx_tx.sv */
// Transmitting end: transport packing, scrambling, alignment and 8b/10b coding.
`timescale 1ns/100ps
`default_nettype none
`include "jtx_defs.svh"
module jtx_tx #(
  parameter int LANES = 2,
  parameter int SAMPLE_W = 12,
  parameter int FRAMES_PER_MF = 32
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_transport_mode_select,
  input wire logic i_scramble_enable,
  input wire logic i_sel_64b66b,
  input wire logic i_sysref,
  input wire logic [LANES*SAMPLE_W-1:0] i_sample,
  output logic o_sample_ready,
  output var jtx_pkg::jtx_tx_state_t o_link_state,
  jtx_link_if.tx link
);
  import jtx_pkg::*;

  // Padding bits that fill each sample container.
  localparam int PAD = `JTX_CONT_W - SAMPLE_W;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // SYNC and SYSREF come from outside; each passes two flops, the third is for edges.
  logic sync_meta_reg, sync_reg, sync_d_reg;
  logic sref_meta_reg, sref_reg, sref_d_reg;

  // Idle SYNC is high, so the pipe resets high to avoid a false request.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      sync_d_reg <= 1'b1;
      sref_meta_reg <= 1'b0;
      sref_reg <= 1'b0;
      sref_d_reg <= 1'b0;
    end else begin
      sync_meta_reg <= link.sync_n;
      sync_reg <= sync_meta_reg;
      sync_d_reg <= sync_reg;
      sref_meta_reg <= i_sysref;
      sref_reg <= sref_meta_reg;
      sref_d_reg <= sref_reg;
    end
  end

  wire sync_rise = sync_reg & ~sync_d_reg;
  wire sref_rise = sref_reg & ~sref_d_reg;

  // ==========================================================
  // Local multiframe clock
  // ==========================================================
  // The frame size follows the selected mode alone.
  wire [3:0] frame_len = jtx_frame_octets(i_transport_mode_select);
  // Octets per multiframe less one; K frames of F octets.
  wire [10:0] mf_last = 11'(frame_len * FRAMES_PER_MF - 1);
  wire [10:0] frame_mask = 11'(frame_len - 4'h1);
  // Octet position inside the multiframe; one octet per lane per clock.
  logic [10:0] oct_reg;
  wire lmfc_edge = (oct_reg == mf_last);
  wire frame_end = ((oct_reg & frame_mask) == frame_mask);
  wire even_oct = ~oct_reg[0];

  // SYSREF forces a known phase; otherwise the counter wraps each multiframe.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oct_reg <= '0;
    end else if (sref_rise || lmfc_edge) begin
      oct_reg <= '0;
    end else begin
      oct_reg <= oct_reg + 11'h1;
    end
  end

  // ==========================================================
  // Start-up sequencer
  // ==========================================================
  jtx_tx_state_t state_reg, state_next;
  logic [1:0] mf_reg, mf_next;

  // Commas, wait for a boundary, four alignment multiframes, then data.
  always_comb begin
    state_next = state_reg;
    mf_next = mf_reg;
    case (state_reg)
      JTX_TX_CGS: begin
        // Only a rising SYNC ends the comma phase.
        if (sync_rise) begin
          state_next = JTX_TX_WAIT;
        end
      end
      JTX_TX_WAIT: begin
        if (lmfc_edge) begin
          state_next = JTX_TX_ILAS;
          mf_next = '0;
        end
      end
      JTX_TX_ILAS: begin
        if (lmfc_edge) begin
          if (mf_reg == `JTX_ILAS_LAST_MF) begin
            state_next = JTX_TX_DATA;
          end else begin
            mf_next = mf_reg + 2'h1;
          end
        end
      end
      JTX_TX_DATA: begin
        // Data runs until the receiver drops SYNC.
        state_next = JTX_TX_DATA;
      end
      default: begin
        state_next = JTX_TX_CGS;
      end
    endcase
    // A low SYNC wins in every phase and restarts the link.
    if (!sync_reg) begin
      state_next = JTX_TX_CGS;
    end
  end

  // Sequencer registers.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= JTX_TX_CGS;
      mf_reg <= '0;
    end else begin
      state_reg <= state_next;
      mf_reg <= mf_next;
    end
  end

  wire in_data = (state_reg == JTX_TX_DATA);
  wire in_ilas = (state_reg == JTX_TX_ILAS);
  // The 64b/66b selection forces scrambling whatever the enable holds.
  wire scr_on = i_scramble_enable | i_sel_64b66b;
  // A sample is taken at each even octet; it fills two octets.
  assign o_sample_ready = in_data & even_oct;
  assign o_link_state = state_reg;

  // ==========================================================
  // Alignment sequence content
  // ==========================================================
  // Returns {k, octet}. Never scrambled: the caller bypasses the scrambler.
  function automatic logic [8:0] ilas_octet(input logic [7:0] lane, input logic [10:0] pos,
                                            input logic [1:0] mf);
    logic [8:0] r;
    r = {1'b0, pos[7:0]};
    if (pos == '0) begin
      r = {1'b1, `JTX_K_R};
    end else if (pos == mf_last) begin
      r = {1'b1, `JTX_K_A};
    end else if (mf == 2'h1) begin
      // Configuration octets let the far end compare settings.
      case (pos)
        `JTX_CFG_Q: r = {1'b1, `JTX_K_Q};
        `JTX_CFG_LANE: r = {1'b0, lane};
        `JTX_CFG_L: r = {1'b0, 8'(LANES - 1)};
        `JTX_CFG_F: r = {1'b0, 4'h0, frame_mask[3:0]};
        `JTX_CFG_K: r = {1'b0, 8'(FRAMES_PER_MF - 1)};
        `JTX_CFG_MODE: r = {1'b0, 5'h0, scr_on, i_transport_mode_select};
        default: r = {1'b0, pos[7:0]};
      endcase
    end
    return r;
  endfunction

  // ==========================================================
  // Lanes
  // ==========================================================
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    wire [SAMPLE_W-1:0] smp = i_sample[l*SAMPLE_W +: SAMPLE_W];
    // Low sample bits held for the odd octet of the container.
    logic [SAMPLE_W-9:0] lo_reg;
    logic [14:0] scr_reg;
    // Last octet of the previous frame, for the repeat test.
    logic [7:0] prev_reg;
    logic rd_reg;
    logic [`JTX_CHAR_W-1:0] char_reg;

    // Sample is msb-justified in its container, tail bits zero.
    wire [7:0] raw = even_oct ? smp[SAMPLE_W-1 -: 8] : {lo_reg, {PAD{1'b0}}};
    // Scramble the octet ahead of the coder.
    wire [22:0] scramble_enable = jtx_scramble(scr_reg, raw);
    wire [7:0] dat = scr_on ? scramble_enable[7:0] : raw;
    // Scrambled: fixed values; plain: a repeated last octet.
    wire sub_f = frame_end & (scr_on ? (dat == `JTX_K_F) : (dat == prev_reg));
    wire sub_a = lmfc_edge & (scr_on ? (dat == `JTX_K_A) : (dat == prev_reg));
    wire [8:0] ilas = ilas_octet(8'(l), oct_reg, mf_reg);
    // Commas whenever neither alignment nor data is due.
    wire [8:0] sel = in_ilas ? ilas :
                     !in_data ? {1'b1, `JTX_K_K} :
                     sub_a ? {1'b1, `JTX_K_A} :
                     sub_f ? {1'b1, `JTX_K_F} : {1'b0, dat};
    // Disparity-tracked coding of every octet.
    wire [10:0] enc = jtx_encode(sel[7:0], sel[8], rd_reg);

    // Scrambler restarts from zero at each data phase so both ends agree at once.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        lo_reg <= '0;
        scr_reg <= '0;
        prev_reg <= '0;
        rd_reg <= 1'b0;
        char_reg <= '0;
      end else begin
        rd_reg <= enc[10];
        char_reg <= enc[`JTX_CHAR_W-1:0];
        scr_reg <= in_data ? scramble_enable[22:8] : '0;
        if (in_data && even_oct) begin
          lo_reg <= smp[SAMPLE_W-9:0];
        end
        // Cleared outside data so both ends start each link from the same history.
        if (!in_data) begin
          prev_reg <= '0;
        end else if (frame_end) begin
          prev_reg <= dat;
        end
      end
    end

    assign link.chars[l*`JTX_CHAR_W +: `JTX_CHAR_W] = char_reg;
  end
endmodule
`default_nettype wire
